// ==== hw/dbw_unit.sv ====
// Debug breakpoint and watchpoint unit of one processor tile
`timescale 1ns/1ps
// --------------------
// --------------------
module dbw_unit #(
    parameter int NUM_THREADS = 8,
    parameter int NUM_UNITS = 4,
    parameter int NUM_SCRATCH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pipeline observation
    input wire dbw_pkg::dbw_exec_s exec_i,
    input wire dbw_pkg::dbw_mem_s mem_i,
    input wire dbw_pkg::dbw_res_s res_i,
    input wire logic debug_return,
    // Host request bit from tile configuration
    input wire logic host_debug_req,
    // Processor register access
    input wire dbw_pkg::dbw_regreq_s reg_req,
    output logic reg_rd_valid,
    output logic [31:0] reg_rd_data,
    // Tile configuration access to the scratch words
    input wire logic cfg_valid,
    input wire logic cfg_we,
    input wire logic [2:0] cfg_index,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_rd_valid,
    output logic [31:0] cfg_rd_data,
    // Debug status towards the pipeline
    output logic debug_irq,
    output logic debug_mode,
    output logic [7:0] thread_stop,
    output logic [7:0] remote_read_thread,
    output logic [4:0] remote_read_regnum
);

    // --------------------
    // State
    // --------------------
    dbw_pkg::dbw_state_s state_q;
    dbw_pkg::dbw_state_s state_d;

    // --------------------
    // Trigger evaluation
    // --------------------
    logic [NUM_UNITS-1:0] ibp_hit;
    logic [NUM_UNITS-1:0] dwp_hit;
    logic [NUM_UNITS-1:0] rwp_hit;
    logic [NUM_UNITS-1:0] dwp_cond_a;
    logic [NUM_UNITS-1:0] dwp_cond_b;
    logic [NUM_UNITS-1:0] rwp_cond_a;

    // Each unit compares against the slot it watches; a unit never fires while disabled
    always_comb begin
        for (int i = 0; i < NUM_UNITS; i++) begin
            ibp_hit[i] = state_q.ibp_ctrl[i][dbw_pkg::DBW_CTRL_EN_BIT]
                && state_q.ibp_ctrl[i][dbw_pkg::DBW_CTRL_TEN_LSB + exec_i.thread]
                && exec_i.valid
                && (state_q.ibp_ctrl[i][dbw_pkg::DBW_CTRL_COND_BIT]
                    ? (exec_i.pc != state_q.ibp_addr[i])
                    : (exec_i.pc == state_q.ibp_addr[i]));
            dwp_cond_a[i] = mem_i.addr >= state_q.dwp_a[i];
            dwp_cond_b[i] = mem_i.addr <= state_q.dwp_b[i];
            dwp_hit[i] = state_q.dwp_ctrl[i][dbw_pkg::DBW_CTRL_EN_BIT]
                && state_q.dwp_ctrl[i][dbw_pkg::DBW_CTRL_TEN_LSB + mem_i.thread]
                && mem_i.valid
                && (!mem_i.load || state_q.dwp_ctrl[i][dbw_pkg::DBW_CTRL_LOAD_BIT])
                && (state_q.dwp_ctrl[i][dbw_pkg::DBW_CTRL_COND_BIT]
                    ? (dwp_cond_a[i] || dwp_cond_b[i])
                    : (dwp_cond_a[i] && dwp_cond_b[i]));
            rwp_cond_a[i] = (res_i.id & state_q.rwp_mask[i]) == state_q.rwp_value[i];
            rwp_hit[i] = state_q.rwp_ctrl[i][dbw_pkg::DBW_CTRL_EN_BIT]
                && state_q.rwp_ctrl[i][dbw_pkg::DBW_CTRL_TEN_LSB + res_i.thread]
                && res_i.valid
                && (state_q.rwp_ctrl[i][dbw_pkg::DBW_CTRL_COND_BIT]
                    ? !rwp_cond_a[i] : rwp_cond_a[i]);
        end
    end

    // Lowest index of a hit vector, zero when none
    function automatic logic [1:0] lowest_index(input logic [NUM_UNITS-1:0] hits);
        logic [1:0] idx;
        idx = 2'h0;
        for (int j = NUM_UNITS - 1; j >= 0; j--) begin
            if (hits[j]) begin
                idx = 2'(j);
            end
        end
        return idx;
    endfunction : lowest_index

    // --------------------
    // Register read view
    // --------------------
    logic [31:0] rd_mux;
    logic [3:0] rd_sub;

    // Reserved bits read as zero; unmapped numbers read as zero too
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_sub = reg_req.addr[3:0];
        case (reg_req.addr)
            dbw_pkg::DBW_REG_SAVED_PC: rd_mux = state_q.saved_pc;
            dbw_pkg::DBW_REG_SAVED_SP: rd_mux = state_q.saved_sp;
            dbw_pkg::DBW_REG_RREAD_THREAD: rd_mux = {24'h00_0000, state_q.rread_thread};
            dbw_pkg::DBW_REG_RREAD_REGNUM: rd_mux = {27'h000_0000, state_q.rread_regnum};
            dbw_pkg::DBW_REG_IRQ_CAUSE: rd_mux = {14'h0000, state_q.cause_bp, state_q.cause_thread,
                                                  5'h00, state_q.cause};
            dbw_pkg::DBW_REG_IRQ_DATA: rd_mux = state_q.irq_data;
            dbw_pkg::DBW_REG_STOP_MASK: rd_mux = {24'h00_0000, state_q.stop_mask};
            default: begin
                if (reg_req.addr[7:3] == dbw_pkg::DBW_REG_SCRATCH[7:3]) begin
                    rd_mux = state_q.scratch[rd_sub[2:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_IBP_ADDR[7:2]) begin
                    rd_mux = state_q.ibp_addr[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_IBP_CTRL[7:2]) begin
                    rd_mux = state_q.ibp_ctrl[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_DWP_ADDR_A[7:2]) begin
                    rd_mux = state_q.dwp_a[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_DWP_ADDR_B[7:2]) begin
                    rd_mux = state_q.dwp_b[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_DWP_CTRL[7:2]) begin
                    rd_mux = state_q.dwp_ctrl[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_RWP_MASK[7:2]) begin
                    rd_mux = state_q.rwp_mask[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_RWP_VALUE[7:2]) begin
                    rd_mux = state_q.rwp_value[rd_sub[1:0]];
                end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_RWP_CTRL[7:2]) begin
                    rd_mux = state_q.rwp_ctrl[rd_sub[1:0]];
                end
            end
        endcase
    end

    // --------------------
    // Next state
    // --------------------
    logic wr_ok;
    logic trig_any;
    logic [31:0] ctrl_wmask;
    logic [31:0] dctrl_wmask;

    // Writable bits of the control words: enables, condition, thread field, and the load bit in data watchpoint control
    assign ctrl_wmask = 32'h00FF_0003;
    assign dctrl_wmask = 32'h00FF_0007;
    // Processor writes only take effect while in debug mode
    assign wr_ok = reg_req.valid && reg_req.we && (state_q.mode == dbw_pkg::DBW_DEBUG);
    assign trig_any = host_debug_req || (exec_i.valid && exec_i.debug_call_instr)
        || (|ibp_hit) || (|dwp_hit) || (|rwp_hit);

    always_comb begin
        state_d = state_q;
        state_d.irq = 1'b0;
        state_d.rd_valid = reg_req.valid && !reg_req.we;
        state_d.rd_data = (reg_req.valid && !reg_req.we) ? rd_mux : state_q.rd_data;
        state_d.cfg_rd_valid = cfg_valid && !cfg_we;
        state_d.cfg_rd_data = (cfg_valid && !cfg_we) ? state_q.scratch[cfg_index] : state_q.cfg_rd_data;

        // Register writes, processor side
        if (wr_ok) begin
            case (reg_req.addr)
                dbw_pkg::DBW_REG_SAVED_PC: state_d.saved_pc = reg_req.wdata;
                dbw_pkg::DBW_REG_SAVED_SP: state_d.saved_sp = reg_req.wdata;
                dbw_pkg::DBW_REG_RREAD_THREAD: state_d.rread_thread = reg_req.wdata[7:0];
                dbw_pkg::DBW_REG_RREAD_REGNUM: state_d.rread_regnum = reg_req.wdata[4:0];
                dbw_pkg::DBW_REG_IRQ_CAUSE: begin
                    state_d.cause_bp = reg_req.wdata[dbw_pkg::DBW_CAUSE_BP_LSB +: 2];
                    state_d.cause_thread = reg_req.wdata[dbw_pkg::DBW_CAUSE_THR_LSB +: 8];
                    state_d.cause = reg_req.wdata[2:0];
                end
                dbw_pkg::DBW_REG_IRQ_DATA: state_d.irq_data = reg_req.wdata;
                dbw_pkg::DBW_REG_STOP_MASK: state_d.stop_mask = reg_req.wdata[7:0];
                default: begin
                    if (reg_req.addr[7:3] == dbw_pkg::DBW_REG_SCRATCH[7:3]) begin
                        state_d.scratch[reg_req.addr[2:0]] = reg_req.wdata;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_IBP_ADDR[7:2]) begin
                        state_d.ibp_addr[reg_req.addr[1:0]] = reg_req.wdata;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_IBP_CTRL[7:2]) begin
                        state_d.ibp_ctrl[reg_req.addr[1:0]] = reg_req.wdata & ctrl_wmask;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_DWP_ADDR_A[7:2]) begin
                        state_d.dwp_a[reg_req.addr[1:0]] = reg_req.wdata;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_DWP_ADDR_B[7:2]) begin
                        state_d.dwp_b[reg_req.addr[1:0]] = reg_req.wdata;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_DWP_CTRL[7:2]) begin
                        state_d.dwp_ctrl[reg_req.addr[1:0]] = reg_req.wdata & dctrl_wmask;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_RWP_MASK[7:2]) begin
                        state_d.rwp_mask[reg_req.addr[1:0]] = reg_req.wdata;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_RWP_VALUE[7:2]) begin
                        state_d.rwp_value[reg_req.addr[1:0]] = reg_req.wdata;
                    end else if (reg_req.addr[7:2] == dbw_pkg::DBW_REG_RWP_CTRL[7:2]) begin
                        state_d.rwp_ctrl[reg_req.addr[1:0]] = reg_req.wdata & ctrl_wmask;
                    end
                end
            endcase
        end

        // Configuration side writes the same scratch words; the processor wins a same-word clash
        if (cfg_valid && cfg_we
            && !(wr_ok && reg_req.addr[7:3] == dbw_pkg::DBW_REG_SCRATCH[7:3] && reg_req.addr[2:0] == cfg_index)) begin
            state_d.scratch[cfg_index] = cfg_wdata;
        end

        // Mode sequencing: triggers are only taken while running
        case (state_q.mode)
            dbw_pkg::DBW_RUN: begin
                if (trig_any) begin
                    state_d.mode = dbw_pkg::DBW_DEBUG;
                    state_d.irq = 1'b1;
                    state_d.saved_pc = exec_i.pc;
                    state_d.saved_sp = exec_i.sp;
                    state_d.cause_thread = {5'h00, exec_i.thread};
                    state_d.cause_bp = 2'h0;
                    // Host first, then debug call, instruction, data, resource
                    if (host_debug_req) begin
                        state_d.cause = dbw_pkg::DBW_CAUSE_HOST;
                        state_d.cause_thread = 8'h00;
                    end else if (exec_i.valid && exec_i.debug_call_instr) begin
                        state_d.cause = dbw_pkg::DBW_CAUSE_CALL;
                    end else if (|ibp_hit) begin
                        state_d.cause = dbw_pkg::DBW_CAUSE_IBP;
                        state_d.cause_bp = lowest_index(ibp_hit);
                    end else if (|dwp_hit) begin
                        state_d.cause = dbw_pkg::DBW_CAUSE_DWP;
                        state_d.cause_bp = lowest_index(dwp_hit);
                        state_d.cause_thread = {5'h00, mem_i.thread};
                        state_d.irq_data = mem_i.addr;
                    end else begin
                        state_d.cause = dbw_pkg::DBW_CAUSE_RWP;
                        state_d.cause_bp = lowest_index(rwp_hit);
                        state_d.cause_thread = {5'h00, res_i.thread};
                        state_d.irq_data = res_i.id;
                    end
                end
            end
            dbw_pkg::DBW_DEBUG: begin
                if (debug_return) begin
                    state_d.mode = dbw_pkg::DBW_RUN;
                end
            end
            default: state_d.mode = dbw_pkg::DBW_RUN;
        endcase
    end

    // --------------------
    // State register
    // --------------------
    // Whole state clears; zero is a safe start for the data words too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // --------------------
    // Outputs
    // --------------------
    assign reg_rd_valid = state_q.rd_valid;
    assign reg_rd_data = state_q.rd_data;
    assign cfg_rd_valid = state_q.cfg_rd_valid;
    assign cfg_rd_data = state_q.cfg_rd_data;
    assign debug_irq = state_q.irq;
    assign debug_mode = (state_q.mode == dbw_pkg::DBW_DEBUG);
    // Stopped threads only hold while running, so the debugger can still step them
    assign thread_stop = (state_q.mode == dbw_pkg::DBW_DEBUG) ? 8'h00 : state_q.stop_mask;
    assign remote_read_thread = state_q.rread_thread;
    assign remote_read_regnum = state_q.rread_regnum;

endmodule : dbw_unit

// ==== include/dbw_pkg.sv ====
// Constants, types and register map of the debug breakpoint and watchpoint unit
package dbw_pkg;

    // --------------------
    // Register numbers (processor status register space)
    // --------------------
    localparam logic [7:0] DBW_REG_SAVED_PC = 8'h11;
    localparam logic [7:0] DBW_REG_SAVED_SP = 8'h12;
    localparam logic [7:0] DBW_REG_RREAD_THREAD = 8'h13;
    localparam logic [7:0] DBW_REG_RREAD_REGNUM = 8'h14;
    localparam logic [7:0] DBW_REG_IRQ_CAUSE = 8'h15;
    localparam logic [7:0] DBW_REG_IRQ_DATA = 8'h16;
    localparam logic [7:0] DBW_REG_STOP_MASK = 8'h18;
    localparam logic [7:0] DBW_REG_SCRATCH = 8'h20;
    localparam logic [7:0] DBW_REG_IBP_ADDR = 8'h30;
    localparam logic [7:0] DBW_REG_IBP_CTRL = 8'h40;
    localparam logic [7:0] DBW_REG_DWP_ADDR_A = 8'h50;
    localparam logic [7:0] DBW_REG_DWP_ADDR_B = 8'h60;
    localparam logic [7:0] DBW_REG_DWP_CTRL = 8'h70;
    localparam logic [7:0] DBW_REG_RWP_MASK = 8'h80;
    localparam logic [7:0] DBW_REG_RWP_VALUE = 8'h90;
    localparam logic [7:0] DBW_REG_RWP_CTRL = 8'h9C;

    // --------------------
    // Field positions and cause codes
    // --------------------
    localparam int DBW_CTRL_EN_BIT = 0;
    localparam int DBW_CTRL_COND_BIT = 1;
    localparam int DBW_CTRL_LOAD_BIT = 2;
    localparam int DBW_CTRL_TEN_LSB = 16;
    localparam int DBW_CAUSE_THR_LSB = 8;
    localparam int DBW_CAUSE_BP_LSB = 16;
    localparam logic [2:0] DBW_CAUSE_NONE = 3'h0;
    localparam logic [2:0] DBW_CAUSE_HOST = 3'h1;
    localparam logic [2:0] DBW_CAUSE_CALL = 3'h2;
    localparam logic [2:0] DBW_CAUSE_IBP = 3'h3;
    localparam logic [2:0] DBW_CAUSE_DWP = 3'h4;
    localparam logic [2:0] DBW_CAUSE_RWP = 3'h5;
    localparam logic [31:0] DBW_CTRL_RESET = 32'h0000_0000;

    // --------------------
    // Types
    // --------------------
    typedef enum logic [0:0] {
        DBW_RUN = 1'b0,
        DBW_DEBUG = 1'b1
    } dbw_mode_e;

    // Instruction issue slot seen by the unit
    typedef struct packed {
        logic valid;
        logic [2:0] thread;
        logic [31:0] pc;
        logic [31:0] sp;
        logic debug_call_instr;
    } dbw_exec_s;

    // Memory operation with its effective address
    typedef struct packed {
        logic valid;
        logic load;
        logic [2:0] thread;
        logic [31:0] addr;
    } dbw_mem_s;

    // Resource instruction with its resource identifier
    typedef struct packed {
        logic valid;
        logic [2:0] thread;
        logic [31:0] id;
    } dbw_res_s;

    // Register access request
    typedef struct packed {
        logic valid;
        logic we;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dbw_regreq_s;

    // Complete state of the unit
    typedef struct packed {
        dbw_mode_e mode;
        logic irq;
        logic [31:0] saved_pc;
        logic [31:0] saved_sp;
        logic [7:0] rread_thread;
        logic [4:0] rread_regnum;
        logic [1:0] cause_bp;
        logic [7:0] cause_thread;
        logic [2:0] cause;
        logic [31:0] irq_data;
        logic [7:0] stop_mask;
        logic [7:0][31:0] scratch;
        logic [3:0][31:0] ibp_addr;
        logic [3:0][31:0] ibp_ctrl;
        logic [3:0][31:0] dwp_a;
        logic [3:0][31:0] dwp_b;
        logic [3:0][31:0] dwp_ctrl;
        logic [3:0][31:0] rwp_mask;
        logic [3:0][31:0] rwp_value;
        logic [3:0][31:0] rwp_ctrl;
        logic rd_valid;
        logic [31:0] rd_data;
        logic cfg_rd_valid;
        logic [31:0] cfg_rd_data;
    } dbw_state_s;

endpackage : dbw_pkg

// ==== testbench/dbw_unit_asserts.sv ====
// Port checker of the debug unit
`timescale 1ns/1ps
// --------------------
// Checker
// --------------------
module dbw_unit_asserts (
    // Clock, reset and requests
    input wire logic clk,
    input wire logic rst_n,
    input wire dbw_pkg::dbw_regreq_s reg_req,
    input wire logic debug_return,
    input wire logic host_debug_req,
    input wire logic cfg_valid,
    input wire logic cfg_we,
    // Answers and status
    input wire logic reg_rd_valid,
    input wire logic cfg_rd_valid,
    input wire logic debug_irq,
    input wire logic debug_mode,
    input wire logic [7:0] thread_stop,
    input wire logic [7:0] remote_read_thread,
    input wire logic [4:0] remote_read_regnum
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Entry pulse only on the step from run into debug mode
    a_irq_entry: assert property (debug_irq |-> debug_mode && !$past(debug_mode))
        else $error("entry pulse outside a mode change");
    a_host_entry: assert property (host_debug_req && !debug_mode |=> debug_irq ##1 !debug_irq)
        else $error("host request not taken");
    // Triggers are dropped, not queued, while in debug mode
    a_no_retrig: assert property (debug_mode |=> !debug_irq)
        else $error("entry while already in debug mode");
    a_stop_debug: assert property (debug_mode |-> thread_stop == 8'h00)
        else $error("threads stopped in debug mode");
    a_stop_hold: assert property (!debug_mode ##1 !debug_mode |-> $stable(thread_stop))
        else $error("stop mask moved while running");
    a_ret_leave: assert property (debug_mode && !debug_return |=> debug_mode)
        else $error("debug mode left without return");
    a_ret_done: assert property (debug_mode && debug_return |=> !debug_mode)
        else $error("return not taken");
    a_rd_answer: assert property (reg_req.valid && !reg_req.we |=> reg_rd_valid)
        else $error("register read unanswered");
    a_rd_quiet: assert property (!(reg_req.valid && !reg_req.we) |=> !reg_rd_valid)
        else $error("spurious read answer");
    a_cfg_answer: assert property (cfg_valid && !cfg_we |=> cfg_rd_valid)
        else $error("scratch read unanswered");
    // Operands only change through debug-mode writes
    a_operand_hold: assert property (!debug_mode |=> $stable({remote_read_thread, remote_read_regnum}))
        else $error("operand moved while running");

    c_entry: cover property (debug_irq);
    c_cfg_read: cover property (cfg_rd_valid);
    c_step: cover property (debug_mode && debug_return);
endmodule : dbw_unit_asserts

bind dbw_unit dbw_unit_asserts u_asserts (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .debug_return(debug_return), .host_debug_req(host_debug_req),
    .cfg_valid(cfg_valid), .cfg_we(cfg_we), .reg_rd_valid(reg_rd_valid), .cfg_rd_valid(cfg_rd_valid),
    .debug_irq(debug_irq), .debug_mode(debug_mode), .thread_stop(thread_stop),
    .remote_read_thread(remote_read_thread), .remote_read_regnum(remote_read_regnum));

// ==== testbench/dbw_host_model.sv ====
// External debug host: register port, scratch port and request bit
`timescale 1ns/1ps
// --------------------
// Host model
// --------------------
module dbw_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output dbw_pkg::dbw_regreq_s reg_req,
    input wire logic reg_rd_valid,
    input wire logic [31:0] reg_rd_data,
    // Configuration port and request bit
    output logic cfg_valid,
    output logic cfg_we,
    output logic [2:0] cfg_index,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_rd_valid,
    input wire logic [31:0] cfg_rd_data,
    output logic host_debug_req
);
    initial begin
        reg_req = '0;
        {cfg_valid, cfg_we, cfg_index, cfg_wdata} = '0;
        host_debug_req = 1'b0;
    end

    // Held over one edge; released fields are inverted so stale values never pass
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1 reg_req = {1'b1, we, a, d};
        @(posedge clk);
        #1 reg_req = {1'b0, ~reg_req[40:0]};
        q = (reg_rd_valid === 1'b1) ? reg_rd_data : 'x;
    endtask : acc

    // Scratch words through the configuration side
    task automatic cacc(input logic we, input logic [2:0] i, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1 {cfg_valid, cfg_we, cfg_index, cfg_wdata} = {1'b1, we, i, d};
        @(posedge clk);
        #1 cfg_valid = 1'b0;
        {cfg_we, cfg_index, cfg_wdata} = ~{cfg_we, cfg_index, cfg_wdata};
        q = (cfg_rd_valid === 1'b1) ? cfg_rd_data : 'x;
    endtask : cacc

    // Request bit of the host interrupt register
    task automatic hreq(input logic v);
        host_debug_req = v;
    endtask : hreq
endmodule : dbw_host_model

// ==== testbench/dbw_unit_bench.sv ====
// Self-checking bench of the debug unit
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// --------------------
// Bench top
// --------------------
module dbw_unit_bench;
    logic clk = 0;
    logic rst_n = 0;
    dbw_pkg::dbw_exec_s exec_i = '0;
    dbw_pkg::dbw_mem_s mem_i = '0;
    dbw_pkg::dbw_res_s res_i = '0;
    dbw_pkg::dbw_regreq_s reg_req;
    logic debug_return = 0;
    logic host_debug_req, reg_rd_valid, cfg_valid, cfg_we, cfg_rd_valid, debug_irq, debug_mode;
    logic [2:0] cfg_index, t;
    logic [31:0] reg_rd_data, cfg_wdata, cfg_rd_data, q, r, lo, hi, m;
    logic [31:0] mdl [256] = '{default: '0};
    logic [7:0] thread_stop, remote_read_thread;
    logic [4:0] remote_read_regnum;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    bit in_dbg = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    dbw_unit uut (.clk(clk), .rst_n(rst_n), .exec_i(exec_i), .mem_i(mem_i), .res_i(res_i),
        .debug_return(debug_return), .host_debug_req(host_debug_req), .reg_req(reg_req),
        .reg_rd_valid(reg_rd_valid), .reg_rd_data(reg_rd_data), .cfg_valid(cfg_valid), .cfg_we(cfg_we),
        .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data),
        .debug_irq(debug_irq), .debug_mode(debug_mode), .thread_stop(thread_stop),
        .remote_read_thread(remote_read_thread), .remote_read_regnum(remote_read_regnum));
    dbw_host_model host (.clk(clk), .reg_req(reg_req), .reg_rd_valid(reg_rd_valid), .reg_rd_data(reg_rd_data),
        .cfg_valid(cfg_valid), .cfg_we(cfg_we), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
        .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data), .host_debug_req(host_debug_req));

    // Writable bits of each register; zero marks a hole in the map
    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a) inside
            8'h11, 8'h12, 8'h16, [8'h20:8'h27], [8'h30:8'h33], [8'h50:8'h53], [8'h60:8'h63]: return 32'hFFFFFFFF;
            [8'h80:8'h83], [8'h90:8'h93]: return 32'hFFFFFFFF;
            8'h13, 8'h18: return 32'h000000FF;
            8'h14: return 32'h0000001F;
            8'h15: return 32'h0003FF07;
            [8'h40:8'h43], [8'h9C:8'h9F]: return 32'h00FF0003;
            [8'h70:8'h73]: return 32'h00FF0007;
            default: return 32'h00000000;
        endcase
    endfunction : wmask

    // Control word enabling one thread only
    function automatic logic [31:0] ten(input logic [2:0] th, input logic [15:0] low);
        return {8'h00, 8'h01 << th, low};
    endfunction : ten

    // Writes land in the model only while in debug mode
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        host.acc(1'b1, a, d, q);
        if (in_dbg) mdl[a] = d & wmask(a);
    endtask : w

    task automatic ck(input logic [7:0] a);
        host.acc(1'b0, a, 32'h00000000, q);
        `CHK(q, mdl[a])
    endtask : ck

    // One unit: two value registers and its control
    task automatic unit(input logic [7:0] ra, input logic [31:0] a, input logic [7:0] rb, input logic [31:0] b,
                        input logic [7:0] rc, input logic [31:0] c);
        w(ra, a);
        w(rb, b);
        w(rc, c);
    endtask : unit

    // Entry at the next edge; captured state folded into the model
    task automatic hit(input logic [2:0] c, input logic [2:0] th, input logic [1:0] b, input logic [31:0] dat);
        logic [31:0] p, s;
        p = exec_i.pc;
        s = exec_i.sp;
        @(posedge clk);
        #1 `CHK({debug_irq, debug_mode}, 2'b11)
        host.hreq(1'b0);
        exec_i = '0;
        mem_i = '0;
        res_i = '0;
        in_dbg = 1;
        mdl[8'h11] = p;
        mdl[8'h12] = s;
        mdl[8'h15] = {14'h0000, b, 5'h00, th, 5'h00, c};
        mdl[8'h16] = dat;
        ck(8'h15);
        ck(8'h16);
        ck(8'h11);
        ck(8'h12);
    endtask : hit

    task automatic enter();
        @(posedge clk);
        #1 host.hreq(1'b1);
        exec_i.pc = $urandom;
        exec_i.sp = $urandom;
        hit(3'h1, 3'h0, 2'h0, mdl[8'h16]);
    endtask : enter

    // Leave with only the thread under test running
    task automatic leave();
        w(8'h18, {24'h000000, ~(8'h01 << t)});
        @(posedge clk);
        #1 debug_return = 1'b1;
        @(posedge clk);
        #1 debug_return = 1'b0;
        in_dbg = 0;
        `CHK({debug_mode, thread_stop}, {1'b0, mdl[8'h18][7:0]})
    endtask : leave

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    initial begin
        void'($urandom(16));
        t = 3'($urandom);
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int a = 0; a < 256; a++) ck(8'(a));
        $display("reset values done");
        enter();
        for (int a = 0; a < 256; a++) w(8'(a), $urandom);
        for (int a = 0; a < 256; a++) ck(8'(a));
        `CHK({remote_read_thread, remote_read_regnum}, {mdl[8'h13][7:0], mdl[8'h14][4:0]})
        for (int i = 0; i < 8; i++) begin
            host.cacc(1'b0, 3'(i), 32'h00000000, q);
            `CHK(q, mdl[8'h20 + i])
        end
        r = $urandom;
        host.cacc(1'b1, 3'h5, r, q);
        mdl[8'h25] = r;
        ck(8'h25);
        for (int i = 0; i < 4; i++) unit(8'(8'h40 + i), 0, 8'(8'h70 + i), 0, 8'(8'h9C + i), 0);
        leave();
        w(8'h20, ~mdl[8'h20]);
        ck(8'h20);
        $display("registers done");
        enter();
        r = $urandom;
        unit(8'h30, r, 8'h30, r, 8'h40, ten(t, 16'h0000));
        unit(8'h31, ~r, 8'h31, ~r, 8'h41, ten(t, 16'h0003));
        unit(8'h32, r, 8'h32, r, 8'h42, ten(t, 16'h0001));
        unit(8'h33, r, 8'h33, r, 8'h43, {8'h00, ~(8'h01 << t), 16'h0001});
        leave();
        exec_i = '{valid: 1'b1, thread: t, pc: r, sp: $urandom, debug_call_instr: 1'b0};
        hit(3'h3, t, 2'h1, mdl[8'h16]);
        lo = {1'b0, 31'($urandom)};
        hi = lo + 32'h00001000;
        unit(8'h50, lo, 8'h60, lo, 8'h70, ten(t, 16'h0001));
        unit(8'h51, hi, 8'h61, hi, 8'h71, ten(t, 16'h0003));
        unit(8'h52, lo, 8'h62, hi, 8'h72, ten(t, 16'h0001));
        leave();
        mem_i = '{valid: 1'b1, load: 1'b1, thread: t, addr: lo + 32'h00000010};
        @(posedge clk);
        #1 `CHK(debug_irq, 1'b0)
        mem_i.load = 1'b0;
        hit(3'h4, t, 2'h1, lo + 32'h00000010);
        m = $urandom;
        r = $urandom;
        unit(8'h81, m, 8'h91, r & m, 8'h9D, ten(t, 16'h0003));
        unit(8'h82, m, 8'h92, r & m, 8'h9E, ten(t, 16'h0001));
        leave();
        res_i = '{valid: 1'b1, thread: t, id: r};
        hit(3'h5, t, 2'h2, r);
        leave();
        exec_i = '{valid: 1'b1, thread: t, pc: $urandom, sp: $urandom, debug_call_instr: 1'b1};
        hit(3'h2, t, 2'h0, mdl[8'h16]);
        leave();
        $display("triggers done");
        results();
    end
endmodule : dbw_unit_bench
